// ---- logic/pptu_regs.vh ----
// register addresses, command fields and encodings for the parallel port and timer unit
`ifndef PPTU_REGS_VH
`define PPTU_REGS_VH

// register addresses, low three bits of the latched address
`define PPTU_ADDR_CS      3'h0
`define PPTU_ADDR_PORT1   3'h1
`define PPTU_ADDR_PORT2   3'h2
`define PPTU_ADDR_PORT3   3'h3
`define PPTU_ADDR_TMR_LO  3'h4
`define PPTU_ADDR_TMR_HI  3'h5

// command byte fields
`define PPTU_CMD_P1_OUT   0
`define PPTU_CMD_P2_OUT   1
`define PPTU_CMD_P3_LO    2
`define PPTU_CMD_P3_HI    3
`define PPTU_CMD_IEN1     4
`define PPTU_CMD_IEN2     5
`define PPTU_CMD_TMR_LO   6
`define PPTU_CMD_TMR_HI   7
`define PPTU_CMD_RST      8'h00

// third port roles
`define PPTU_P3_IN        2'h0
`define PPTU_P3_OUT       2'h1
`define PPTU_P3_ALT3      2'h2
`define PPTU_P3_ALT4      2'h3

// timer commands in command bits 7..6
`define PPTU_TCMD_NOP     2'h0
`define PPTU_TCMD_STOP    2'h1
`define PPTU_TCMD_STOP_TC 2'h2
`define PPTU_TCMD_START   2'h3

// timer output modes in high byte bits 7..6
`define PPTU_TMODE_HALF   2'h0
`define PPTU_TMODE_SQUARE 2'h1
`define PPTU_TMODE_SINGLE 2'h2
`define PPTU_TMODE_DIVN   2'h3

// status byte bit positions
`define PPTU_ST_INTR1     0
`define PPTU_ST_BF1       1
`define PPTU_ST_IEN1      2
`define PPTU_ST_INTR2     3
`define PPTU_ST_BF2       4
`define PPTU_ST_IEN2      5
`define PPTU_ST_TC        6

`endif

// ---- logic/pptu_hsk.v ----
// strobe, buffer-full and interrupt handshake for one byte port
`timescale 1ns/100ps
`default_nettype none
module pptu_hsk (
  input  wire clk_i,     // system clock
  input  wire rst_i,     // synchronous reset
  input  wire en_i,      // strobed mode selected
  input  wire dir_out_i, // port is an output
  input  wire stb_n_i,   // peripheral strobe, low active
  input  wire acc_i,     // cpu read or write of the port
  input  wire inte_i,    // interrupt enable
  output wire bf_o,      // buffer full flag
  output wire intr_o,    // gated interrupt request
  output wire latch_o    // capture input data now
);
  reg  stb_d_reg;  // strobe of last cycle
  reg  bf_reg;     // buffer full state
  reg  intr_reg;   // interrupt pending
  wire stb_fall;   // strobe pulled low
  wire stb_rise;   // strobe released

  assign stb_fall = en_i & stb_d_reg & ~stb_n_i;
  assign stb_rise = en_i & ~stb_d_reg & stb_n_i;
  assign latch_o  = stb_fall & ~dir_out_i;
  assign bf_o     = bf_reg;
  assign intr_o   = intr_reg & inte_i;

  // flag updates, a set in the same cycle as a clear wins
  always @(posedge clk_i) begin
    if (rst_i | ~en_i) begin
      stb_d_reg <= 1'b1;
      bf_reg    <= 1'b0;
      intr_reg  <= 1'b0;
    end else begin
      stb_d_reg <= stb_n_i;
      if (~dir_out_i) begin
        if (stb_fall)
          bf_reg <= 1'b1;
        else if (acc_i)
          bf_reg <= 1'b0;
        if (stb_rise)
          intr_reg <= 1'b1;
        else if (acc_i)
          intr_reg <= 1'b0;
      end else begin
        if (acc_i)
          bf_reg <= 1'b1;
        else if (stb_fall)
          bf_reg <= 1'b0;
        if (stb_rise)
          intr_reg <= 1'b1;
        else if (acc_i)
          intr_reg <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- logic/pptu_timer.v ----
// fourteen-bit down-counting timer with four output modes
`timescale 1ns/100ps
`default_nettype none
`include "pptu_regs.vh"
module pptu_timer #(
  parameter WIDTH = 14  // counter width
) (
  input  wire             clk_i,     // system clock
  input  wire             rst_i,     // synchronous reset
  input  wire             tclk_i,    // timer clock input
  input  wire             lo_wr_i,   // write of low byte
  input  wire             hi_wr_i,   // write of high byte
  input  wire [7:0]       wdata_i,   // write data
  input  wire             cmd_wr_i,  // command byte written
  input  wire [1:0]       cmd_i,     // timer command
  output wire [WIDTH-1:0] count_o,   // present count
  output wire [1:0]       mode_o,    // output mode
  output wire             out_o,     // timer output
  output wire             tc_o       // terminal count pulse
);
  reg  [WIDTH-1:0] len_reg;     // count length
  reg  [WIDTH-1:0] count_reg;   // down counter
  reg  [1:0]       mode_reg;    // output mode
  reg              tclk_d_reg;  // timer clock of last cycle
  reg              run_reg;     // counting
  reg              stop_tc_reg; // stop at next terminal count
  reg              out_reg;     // output level
  reg              tc_reg;      // terminal count pulse
  wire             tick;        // timer clock rising edge
  wire             at_tc;       // this tick reaches terminal count
  wire             square;      // half-count modes
  wire [WIDTH-1:0] half;        // half the length

  assign tick    = tclk_i & ~tclk_d_reg;
  assign at_tc   = tick & run_reg & (count_reg <= {{(WIDTH-1){1'b0}}, 1'b1});
  assign square  = (mode_reg == `PPTU_TMODE_HALF) | (mode_reg == `PPTU_TMODE_SQUARE);
  assign half    = {1'b0, len_reg[WIDTH-1:1]};
  assign count_o = count_reg;
  assign mode_o  = mode_reg;
  assign out_o   = out_reg;
  assign tc_o    = tc_reg;

  always @(posedge clk_i) begin
    if (rst_i) begin
      len_reg     <= {WIDTH{1'b0}};
      count_reg   <= {WIDTH{1'b0}};
      mode_reg    <= `PPTU_TMODE_HALF;
      tclk_d_reg  <= 1'b0;
      run_reg     <= 1'b0;
      stop_tc_reg <= 1'b0;
      out_reg     <= 1'b1;
      tc_reg      <= 1'b0;
    end else begin
      tclk_d_reg <= tclk_i;
      tc_reg     <= at_tc;
      if (lo_wr_i)
        len_reg[7:0] <= wdata_i;
      if (hi_wr_i) begin
        len_reg[WIDTH-1:8] <= wdata_i[WIDTH-9:0];
        mode_reg           <= wdata_i[7:6];
      end
      if (at_tc) begin
        count_reg <= len_reg;
        // single modes stop after one terminal count
        if (stop_tc_reg | (mode_reg == `PPTU_TMODE_HALF) | (mode_reg == `PPTU_TMODE_SINGLE))
          run_reg <= 1'b0;
        stop_tc_reg <= 1'b0;
      end else if (tick & run_reg)
        count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
      if (cmd_wr_i) begin
        case (cmd_i)
          `PPTU_TCMD_STOP: begin
            run_reg <= 1'b0;
          end
          `PPTU_TCMD_STOP_TC: begin
            stop_tc_reg <= run_reg;
          end
          `PPTU_TCMD_START: begin
            if (~run_reg) begin
              count_reg <= len_reg;
              run_reg   <= 1'b1;
            end
            stop_tc_reg <= 1'b0;
          end
          default: begin
          end
        endcase
      end
      // high first half, low second half
      if (~run_reg)
        out_reg <= 1'b1;
      else if (square)
        out_reg <= (count_reg > half);
      else
        // low pulse over the terminal count
        out_reg <= ~(count_reg <= {{(WIDTH-1){1'b0}}, 1'b1});
    end
  end
endmodule
`default_nettype wire

// ---- logic/pptu_top.v ----
// parallel ports, handshake control and timer behind a multiplexed processor bus
//
// Notes on behaviour
// - select when io high, ab3 and ab15-12 low
// - selected cycle drives advance acknowledge, no waits
// - address taken at trailing edge of latch
// - read strobe low puts register on bus
// - write strobe rising edge stores bus data
// - command write sets ports, interrupts, timer command
// - byte ports input or output, basic or strobed
// - six-bit port input, output, or handshake
// - low group serves port one, high port two
// - port one strobed input in modes three, four
// - strobe low latches data, raises buffer full
// - interrupt follows, service lowers buffer full
// - port two write raises buffer full, mode four
// - strobe rising edge raises port two interrupt
// - output-mode bit five holds bus override
// - timer low byte at four, high five
// - timer length bits 13-0, mode 15-14
// - first mode low over second half
// - square mode halves, reloads at terminal count
// - single mode one low pulse, no repeat
// - divide mode repeats low pulse each count
// - command bits seven, six start, stop timer
// - fourteen-bit down counter on timer clock
`timescale 1ns/100ps
`default_nettype none
`include "pptu_regs.vh"
module pptu_top #(
  parameter TMR_WIDTH = 14  // timer counter width
) (
  input  wire       CLK_I,         // 40 MHz system clock
  input  wire       RESET_I,       // synchronous reset, high
  input  wire       IO_M_I,        // high for an io cycle
  input  wire       ALE_I,         // address latch pulse, high
  input  wire [7:0] ADDR_HI_I,     // upper address lines 15..8
  input  wire [7:0] AD_I,          // multiplexed bus, input side
  output wire [7:0] AD_O,          // multiplexed bus, driven data
  output wire       AD_OE_N_O,     // bus drive enable, low drives
  input  wire       RD_N_I,        // read strobe, low
  input  wire       WR_N_I,        // write strobe, low
  output wire       ADV_ACK_N_O,   // advance acknowledge, low
  input  wire [7:0] PORT1_I,       // port one pins in
  output wire [7:0] PORT1_O,       // port one pins out
  output wire       PORT1_OE_N_O,  // port one drive, low drives
  input  wire [7:0] PORT2_I,       // port two pins in
  output wire [7:0] PORT2_O,       // port two pins out
  output wire       PORT2_OE_N_O,  // port two drive, low drives
  input  wire [5:0] PORT3_I,       // six-bit port pins in
  output wire [5:0] PORT3_O,       // six-bit port pins out
  output wire [5:0] PORT3_OE_N_O,  // per-line drive, low drives
  input  wire       TMR_CLK_I,     // timer clock input
  output wire       TIMER_OUT_O,   // timer output
  output wire       OVERRIDE_O     // bus override request, high
);
  // bus cycle tracking
  reg  [2:0] addr_reg;      // latched register address
  reg        sel_reg;       // cycle selects this unit
  reg        done_reg;      // read fall or write rise seen
  reg        rd_d_reg;      // read strobe of last cycle
  reg        wr_d_reg;      // write strobe of last cycle
  reg  [7:0] wdata_reg;     // data seen while write strobe low
  reg        ack_n_reg;     // advance acknowledge out
  reg  [7:0] ad_o_reg;      // read data out
  reg        ad_oe_n_reg;   // bus drive enable out

  // programmable state
  reg  [7:0] cmd_reg;       // command byte
  reg  [7:0] p1_out_reg;    // port one output data
  reg  [7:0] p2_out_reg;    // port two output data
  reg  [7:0] p1_lat_reg;    // port one strobed input latch
  reg  [7:0] p2_lat_reg;    // port two strobed input latch
  reg  [5:0] p3_out_reg;    // six-bit port output data
  reg        tc_flag_reg;   // terminal count seen
  reg        p1_oe_n_reg;   // port one drive enable out
  reg        p2_oe_n_reg;   // port two drive enable out
  reg  [5:0] p3_o_reg;      // six-bit port pins out
  reg  [5:0] p3_oe_n_reg;   // six-bit port enables out
  reg        tout_reg;      // timer output flop
  reg        ovr_reg;       // override output flop

  // combinational helpers
  reg  [7:0] rdata;         // addressed register value
  reg  [5:0] p3_o_next;     // next six-bit pin values
  reg  [5:0] p3_oe_n_next;  // next six-bit enables
  wire       decode;        // io select decode during latch
  wire       rd_fall;       // read strobe went low
  wire       wr_rise;       // write strobe went high
  wire       rd_go;         // selected read begins
  wire       wr_go;         // selected write completes
  wire [1:0] p3_mode;       // six-bit port role
  wire       p1_strobed;    // port one handshake active
  wire       p2_strobed;    // port two handshake active
  wire       p1_acc;        // cpu serviced port one
  wire       p2_acc;        // cpu serviced port two
  wire       bf1;           // port one buffer full
  wire       bf2;           // port two buffer full
  wire       intr1;         // port one interrupt
  wire       intr2;         // port two interrupt
  wire       lat1;          // port one latch strobe
  wire       lat2;          // port two latch strobe
  wire [TMR_WIDTH-1:0] tcount; // present timer count
  wire [1:0] tmode;         // timer mode bits
  wire       tout;          // timer output level
  wire       tc;            // terminal count pulse
  wire [5:0] p3_rd;         // six-bit port read value

  assign decode  = IO_M_I & ~AD_I[3] & (ADDR_HI_I[7:4] == 4'h0);
  assign rd_fall = rd_d_reg & ~RD_N_I;
  assign wr_rise = ~wr_d_reg & WR_N_I;
  assign rd_go   = rd_fall & sel_reg & ~ALE_I;
  assign wr_go   = wr_rise & sel_reg & ~ALE_I;

  // roles taken from the command byte
  assign p3_mode    = cmd_reg[`PPTU_CMD_P3_HI:`PPTU_CMD_P3_LO];
  // port one strobed in modes three and four
  assign p1_strobed = (p3_mode == `PPTU_P3_ALT3) | (p3_mode == `PPTU_P3_ALT4);
  assign p2_strobed = (p3_mode == `PPTU_P3_ALT4);
  // service is a read for inputs and a write for outputs
  assign p1_acc = (addr_reg == `PPTU_ADDR_PORT1) & (cmd_reg[`PPTU_CMD_P1_OUT] ? wr_go : rd_go);
  assign p2_acc = (addr_reg == `PPTU_ADDR_PORT2) & (cmd_reg[`PPTU_CMD_P2_OUT] ? wr_go : rd_go);

  // top outputs straight from flops
  assign AD_O         = ad_o_reg;
  assign AD_OE_N_O    = ad_oe_n_reg;
  assign ADV_ACK_N_O  = ack_n_reg;
  assign PORT1_O      = p1_out_reg;
  assign PORT1_OE_N_O = p1_oe_n_reg;
  assign PORT2_O      = p2_out_reg;
  assign PORT2_OE_N_O = p2_oe_n_reg;
  assign PORT3_O      = p3_o_reg;
  assign PORT3_OE_N_O = p3_oe_n_reg;
  assign TIMER_OUT_O  = tout_reg;
  assign OVERRIDE_O   = ovr_reg;

  // port one handshake, low group of the six-bit port
  // strobes armed once their line is an input
  pptu_hsk u_hsk1 (
    .clk_i     (CLK_I),
    .rst_i     (RESET_I),
    .en_i      (p1_strobed & p3_oe_n_reg[2]),
    .dir_out_i (cmd_reg[`PPTU_CMD_P1_OUT]),
    .stb_n_i   (PORT3_I[2]),
    .acc_i     (p1_acc),
    .inte_i    (cmd_reg[`PPTU_CMD_IEN1]),
    .bf_o      (bf1),
    .intr_o    (intr1),
    .latch_o   (lat1)
  );

  // port two handshake, high group of the six-bit port
  pptu_hsk u_hsk2 (
    .clk_i     (CLK_I),
    .rst_i     (RESET_I),
    .en_i      (p2_strobed & p3_oe_n_reg[5]),
    .dir_out_i (cmd_reg[`PPTU_CMD_P2_OUT]),
    .stb_n_i   (PORT3_I[5]),
    .acc_i     (p2_acc),
    .inte_i    (cmd_reg[`PPTU_CMD_IEN2]),
    .bf_o      (bf2),
    .intr_o    (intr2),
    .latch_o   (lat2)
  );

  // timer section
  pptu_timer #(
    .WIDTH (TMR_WIDTH)
  ) u_timer (
    .clk_i    (CLK_I),
    .rst_i    (RESET_I),
    .tclk_i   (TMR_CLK_I),
    .lo_wr_i  (wr_go & (addr_reg == `PPTU_ADDR_TMR_LO)),
    .hi_wr_i  (wr_go & (addr_reg == `PPTU_ADDR_TMR_HI)),
    .wdata_i  (wdata_reg),
    .cmd_wr_i (wr_go & (addr_reg == `PPTU_ADDR_CS)),
    .cmd_i    (wdata_reg[`PPTU_CMD_TMR_HI:`PPTU_CMD_TMR_LO]),
    .count_o  (tcount),
    .mode_o   (tmode),
    .out_o    (tout),
    .tc_o     (tc)
  );

  // six-bit port read, pin value where input, driven value where output
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_p3rd
      assign p3_rd[gi] = p3_oe_n_reg[gi] ? PORT3_I[gi] : p3_o_reg[gi];
    end
  endgenerate

  always @* begin
    rdata = 8'h00;
    case (addr_reg)
      `PPTU_ADDR_CS: begin
        // status byte
        rdata[`PPTU_ST_INTR1] = intr1;
        rdata[`PPTU_ST_BF1]   = bf1;
        rdata[`PPTU_ST_IEN1]  = cmd_reg[`PPTU_CMD_IEN1];
        rdata[`PPTU_ST_INTR2] = intr2;
        rdata[`PPTU_ST_BF2]   = bf2;
        rdata[`PPTU_ST_IEN2]  = cmd_reg[`PPTU_CMD_IEN2];
        rdata[`PPTU_ST_TC]    = tc_flag_reg;
      end
      `PPTU_ADDR_PORT1: begin
        // basic input live, strobed input latched
        if (cmd_reg[`PPTU_CMD_P1_OUT])
          rdata = p1_out_reg;
        else
          rdata = p1_strobed ? p1_lat_reg : PORT1_I;
      end
      `PPTU_ADDR_PORT2: begin
        if (cmd_reg[`PPTU_CMD_P2_OUT])
          rdata = p2_out_reg;
        else
          rdata = p2_strobed ? p2_lat_reg : PORT2_I;
      end
      `PPTU_ADDR_PORT3: begin
        rdata = {2'h0, p3_rd};
      end
      // timer bytes at four and five
      `PPTU_ADDR_TMR_LO: begin
        rdata = tcount[7:0];
      end
      `PPTU_ADDR_TMR_HI: begin
        rdata = {tmode, tcount[TMR_WIDTH-1:8]};
      end
      default: begin
        rdata = 8'h00;
      end
    endcase
  end

  always @* begin
    p3_o_next    = p3_out_reg;
    p3_oe_n_next = 6'h3F;
    case (p3_mode)
      `PPTU_P3_IN: begin
        p3_oe_n_next = 6'h3F;
      end
      `PPTU_P3_OUT: begin
        p3_oe_n_next = 6'h00;
      end
      `PPTU_P3_ALT3: begin
        // low group carries port one handshake
        p3_o_next    = {p3_out_reg[5:3], 1'b0, bf1, intr1};
        p3_oe_n_next = 6'h04;
      end
      `PPTU_P3_ALT4: begin
        p3_o_next    = {1'b0, bf2, intr2, 1'b0, bf1, intr1};
        p3_oe_n_next = 6'h24;
      end
      default: begin
        p3_oe_n_next = 6'h3F;
      end
    endcase
  end

  // bus cycle tracking and answers
  always @(posedge CLK_I) begin
    if (RESET_I) begin
      addr_reg    <= 3'h0;
      sel_reg     <= 1'b0;
      done_reg    <= 1'b0;
      rd_d_reg    <= 1'b1;
      wr_d_reg    <= 1'b1;
      wdata_reg   <= 8'h00;
      ack_n_reg   <= 1'b1;
      ad_o_reg    <= 8'h00;
      ad_oe_n_reg <= 1'b1;
    end else begin
      rd_d_reg <= RD_N_I;
      wr_d_reg <= WR_N_I;
      // address follows while latch high, freezes at its fall
      if (ALE_I) begin
        addr_reg <= AD_I[2:0];
        sel_reg  <= decode;
        done_reg <= 1'b0;
      end else if (rd_fall | wr_rise) begin
        done_reg <= 1'b1;
      end
      // data captured while strobe low, used at its rise
      if (~WR_N_I)
        wdata_reg <= AD_I;
      // acknowledge from the selected latch until the cycle's strobe is seen
      ack_n_reg <= ~(ALE_I ? decode : (sel_reg & ~done_reg));
      // drive bus while selected read strobe low
      if (rd_go)
        ad_o_reg <= rdata;
      ad_oe_n_reg <= ~(sel_reg & ~ALE_I & ~RD_N_I);
    end
  end

  // register writes and pin state
  always @(posedge CLK_I) begin
    if (RESET_I) begin
      cmd_reg     <= `PPTU_CMD_RST;
      p1_out_reg  <= 8'h00;
      p2_out_reg  <= 8'h00;
      p1_lat_reg  <= 8'h00;
      p2_lat_reg  <= 8'h00;
      p3_out_reg  <= 6'h00;
      tc_flag_reg <= 1'b0;
      p1_oe_n_reg <= 1'b1;
      p2_oe_n_reg <= 1'b1;
      p3_o_reg    <= 6'h00;
      p3_oe_n_reg <= 6'h3F;
      tout_reg    <= 1'b1;
      ovr_reg     <= 1'b0;
    end else begin
      if (wr_go) begin
        case (addr_reg)
          `PPTU_ADDR_CS: begin
            cmd_reg <= wdata_reg;
          end
          `PPTU_ADDR_PORT1: begin
            p1_out_reg <= wdata_reg;
          end
          `PPTU_ADDR_PORT2: begin
            p2_out_reg <= wdata_reg;
          end
          `PPTU_ADDR_PORT3: begin
            p3_out_reg <= wdata_reg[5:0];
          end
          default: begin
          end
        endcase
      end
      if (lat1)
        p1_lat_reg <= PORT1_I;
      if (lat2)
        p2_lat_reg <= PORT2_I;
      // status terminal count flag, set wins over read clear
      if (tc)
        tc_flag_reg <= 1'b1;
      else if (rd_go & (addr_reg == `PPTU_ADDR_CS))
        tc_flag_reg <= 1'b0;
      p1_oe_n_reg <= ~cmd_reg[`PPTU_CMD_P1_OUT];
      p2_oe_n_reg <= ~cmd_reg[`PPTU_CMD_P2_OUT];
      p3_o_reg    <= p3_o_next;
      p3_oe_n_reg <= p3_oe_n_next;
      tout_reg    <= tout;
      // override held while output role and bit five set
      ovr_reg <= (p3_mode == `PPTU_P3_OUT) & p3_out_reg[5];
    end
  end
endmodule
`default_nettype wire

// ---- test/pptu_assertions.sv ----
// bus, handshake and override checker
`timescale 1ns/100ps
`default_nettype none
module pptu_checker (
  input wire logic       CLK_I,        // clock
  input wire logic       RESET_I,      // reset
  input wire logic       IO_M_I,       // io cycle
  input wire logic       ALE_I,        // latch
  input wire logic [7:0] ADDR_HI_I,    // high address
  input wire logic [7:0] AD_I,         // bus in
  input wire logic       RD_N_I,       // read
  input wire logic       WR_N_I,       // write
  input wire logic       ADV_ACK_N_O,  // ack
  input wire logic       AD_OE_N_O,    // bus drive
  input wire logic       PORT1_OE_N_O, // port one drive
  input wire logic [5:0] PORT3_I,      // pins in
  input wire logic [5:0] PORT3_O,      // pins out
  input wire logic [5:0] PORT3_OE_N_O, // pin drive
  input wire logic       OVERRIDE_O    // override
);
  logic [4:0] wr_hist_reg; // recent write strobe samples
  wire        recent_wr = ~&wr_hist_reg;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  // keeps write strobe history
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      wr_hist_reg <= 5'h1F;
    end else begin
      wr_hist_reg <= {wr_hist_reg[3:0], WR_N_I};
    end
  end
  sequence sel_cycle;
    ALE_I && IO_M_I && !AD_I[3] && ADDR_HI_I[7:4] == 4'h0;
  endsequence
  sequence read_start;
    !ALE_I && !ADV_ACK_N_O && $fell(RD_N_I);
  endsequence
  a_ack_on_select: assert property (sel_cycle |=> !ADV_ACK_N_O)
    else $error("no ack");
  a_ack_after_write: assert property ($rose(WR_N_I) && !ADV_ACK_N_O |-> ##2 ADV_ACK_N_O)
    else $error("ack stuck");
  a_read_drives_bus: assert property (read_start |=> !AD_OE_N_O ##1 ADV_ACK_N_O)
    else $error("no read data");
  a_bus_quiet: assert property (RD_N_I && $past(RD_N_I) |-> AD_OE_N_O)
    else $error("bus driven idle");
  a_dir_held: assert property ($changed(PORT1_OE_N_O) |-> recent_wr)
    else $error("direction moved");
  a_override_held: assert property ($changed(OVERRIDE_O) |-> recent_wr)
    else $error("override moved");
  a_bf1_on_strobe: assert property (PORT1_OE_N_O && PORT3_OE_N_O[2] && !PORT3_OE_N_O[1]
    && $fell(PORT3_I[2]) |-> ##[1:3] PORT3_O[1]) else $error("no bf1");
  a_irq2_after_strobe: assert property (PORT3_OE_N_O[5] && !PORT3_OE_N_O[3] && $rose(PORT3_I[5])
    && $past(PORT3_OE_N_O[5]) |-> ##[1:3] PORT3_O[3]) else $error("no intr2");
endmodule
bind pptu_top pptu_checker u_chk (
  .CLK_I(CLK_I), .RESET_I(RESET_I), .IO_M_I(IO_M_I), .ALE_I(ALE_I), .ADDR_HI_I(ADDR_HI_I),
  .AD_I(AD_I), .RD_N_I(RD_N_I), .WR_N_I(WR_N_I), .ADV_ACK_N_O(ADV_ACK_N_O), .AD_OE_N_O(AD_OE_N_O),
  .PORT1_OE_N_O(PORT1_OE_N_O), .PORT3_I(PORT3_I), .PORT3_O(PORT3_O),
  .PORT3_OE_N_O(PORT3_OE_N_O), .OVERRIDE_O(OVERRIDE_O)
);
`default_nettype wire

// ---- test/pptu_host.sv ----
// host processor model running bus cycles
`timescale 1ns/100ps
`default_nettype none
module pptu_host (
  input  wire logic       clk_i,     // clock
  input  wire logic [7:0] rd_data_i, // unit data
  input  wire logic       drv_n_i,   // unit drives
  output var  logic       io_m_o,    // io cycle
  output var  logic       ale_o,     // latch
  output var  logic [7:0] addr_hi_o, // high address
  output var  logic [7:0] ad_o,      // bus out
  output var  logic       rd_n_o,    // read
  output var  logic       wr_n_o     // write
);
  initial begin
    {io_m_o, ale_o, rd_n_o, wr_n_o, addr_hi_o, ad_o} = {4'h3, 16'h0000};
  end
  // one cycle; released bus shows inverted value
  task automatic xfer(input logic wr, input logic io, input logic [7:0] hi, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    integer n;
    q = 8'h00;
    @(posedge clk_i) #1;
    {io_m_o, ale_o, addr_hi_o, ad_o} = {io, 1'b1, hi, a};
    repeat (2) @(posedge clk_i);
    #1 ale_o = 1'b0;
    ad_o = ~a;
    @(posedge clk_i) #1;
    if (wr) begin
      {ad_o, wr_n_o} = {d, 1'b0};
      repeat (2) @(posedge clk_i);
      #1 wr_n_o = 1'b1;
      ad_o = ~d;
    end else begin
      // strobe held until the unit answers, six cycles at most
      rd_n_o = 1'b0;
      n = 0;
      do begin
        @(posedge clk_i) #1;
        n = n + 1;
      end while (drv_n_i !== 1'b0 && n < 6);
      q = rd_data_i;
      rd_n_o = 1'b1;
    end
    io_m_o = 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
  endtask
endmodule
`default_nettype wire

// ---- test/tb_parallel_port_timer_unit.sv ----
// self-checking bench for the port and timer unit
`timescale 1ns/100ps
`default_nettype none
module tb_parallel_port_timer_unit;
  logic       clk, rst, tclk;             // clocks, reset
  logic [7:0] p1_in, p2_in, q;            // pins, read data
  logic [5:0] p3_in;                      // control pins, pulled high
  integer     fail_count, comparisons, pulses;
  wire  [7:0] ad_out, p1_out, p2_out, h_ad, h_hi;
  wire  [5:0] p3_out, p3_oe_n;
  wire        ad_oe_n, ack_n, p1_oe_n, p2_oe_n, t_out, ovr, h_io, h_ale, h_rd_n, h_wr_n;
  wire  [7:0] ad_bus = ad_oe_n ? h_ad : ad_out;                 // shared bus level
  wire  [7:0] p1_pin = p1_oe_n ? p1_in : p1_out;
  wire  [7:0] p2_pin = p2_oe_n ? p2_in : p2_out;
  wire  [5:0] p3_pin = (p3_oe_n & p3_in) | (~p3_oe_n & p3_out);
  pptu_top dut (
    .CLK_I(clk), .RESET_I(rst), .IO_M_I(h_io), .ALE_I(h_ale), .ADDR_HI_I(h_hi), .AD_I(ad_bus),
    .AD_O(ad_out), .AD_OE_N_O(ad_oe_n), .RD_N_I(h_rd_n), .WR_N_I(h_wr_n), .ADV_ACK_N_O(ack_n),
    .PORT1_I(p1_pin), .PORT1_O(p1_out), .PORT1_OE_N_O(p1_oe_n), .PORT2_I(p2_pin),
    .PORT2_O(p2_out), .PORT2_OE_N_O(p2_oe_n), .PORT3_I(p3_pin), .PORT3_O(p3_out),
    .PORT3_OE_N_O(p3_oe_n), .TMR_CLK_I(tclk), .TIMER_OUT_O(t_out), .OVERRIDE_O(ovr)
  );
  pptu_host h (
    .clk_i(clk), .rd_data_i(ad_out), .drv_n_i(ad_oe_n), .io_m_o(h_io), .ale_o(h_ale),
    .addr_hi_o(h_hi), .ad_o(h_ad), .rd_n_o(h_rd_n), .wr_n_o(h_wr_n)
  );
  always @(negedge t_out) pulses = pulses + 1;
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    h.xfer(1'b1, 1'b1, 8'h00, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a);
    h.xfer(1'b0, 1'b1, 8'h00, a, 8'h00, q);
  endtask
  task automatic tick(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task stop_test;
    if (fail_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic t_reset;
    chk("idle_pins", {ad_oe_n, t_out, ovr, p3_oe_n}, 9'h1BF);
    rd(8'h00);
    chk("status", q, 8'h00);
  endtask
  task automatic t_ports;
    wr(8'h00, 8'h03);
    wr(8'h01, 8'h55);
    wr(8'h02, 8'hAA);
    h.xfer(1'b1, 1'b0, 8'h00, 8'h01, 8'h00, q);
    h.xfer(1'b1, 1'b1, 8'h10, 8'h01, 8'h00, q);
    wr(8'h09, 8'h00);
    chk("p1_out", {p2_oe_n, p1_oe_n, p1_out}, 10'h055);
    rd(8'h02);
    chk("p2_back", {q, p2_out}, 16'hAAAA);
    wr(8'h00, 8'h00);
    p1_in = 8'hC3;
    rd(8'h01);
    chk("p1_in", {p1_oe_n, q}, 9'h1C3);
  endtask
  task automatic t_override;
    wr(8'h00, 8'h04);
    wr(8'h03, 8'h20);
    wr(8'h01, 8'h00);
    chk("override", {ovr, p3_oe_n, p3_out}, 13'h1020);
    rd(8'h03);
    chk("p3_back", q, 8'h20);
    wr(8'h03, 8'h00);
    chk("override_off", ovr, 1'b0);
  endtask
  task automatic t_strobe_in(input logic [7:0] cmd);
    wr(8'h00, cmd);
    p1_in = 8'h5A;
    tick(1);
    p3_in[2] = 1'b0;
    tick(3);
    chk("bf1_set", p3_out[1:0], 2'h2);
    p1_in = 8'h00;
    p3_in[2] = 1'b1;
    tick(3);
    chk("intr1", p3_out[0], 1'b1);
    rd(8'h01);
    chk("p1_latch", {q, 6'h00, p3_out[1:0]}, 16'h5A00);
  endtask
  task automatic t_strobe_out;
    wr(8'h02, 8'hA5);
    chk("bf2_set", {p2_out, p3_out[4:3]}, 10'h296);
    p3_in[5] = 1'b0;
    tick(3);
    chk("bf2_clear", p3_out[4:3], 2'h0);
    p3_in[5] = 1'b1;
    tick(3);
    rd(8'h00);
    chk("status2", {q, p3_out[3]}, 9'h059);
  endtask
  task automatic t_timer;
    logic [1:0] m;
    for (int i = 0; i < 4; i++) begin
      m = i[1:0];
      wr(8'h04, 8'h06);
      wr(8'h05, {m, 6'h00});
      pulses = 0;
      wr(8'h00, 8'hC0);
      tick(240);
      rd(8'h05);
      chk("tmr_hi", q, {m, 6'h00});
      chk("tmr_pulses", {pulses > 1, pulses > 0}, {m[0], 1'b1});
      wr(8'h00, m[1] ? 8'h80 : 8'h40);
      tick(30);
      rd(8'h04);
      if (m != 2'h1) chk("tmr_count", q, 8'h06);
      rd(8'h00);
      chk("tc_flag", q, 8'h40);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    tclk = 1'b0;
    forever #50 tclk = ~tclk;
  end
  initial begin
    #400000;
    fail_count = fail_count + 1;
    stop_test;
  end
  initial begin
    {rst, p1_in, p2_in, p3_in} = {1'b1, 16'h0000, 6'h3F};
    {fail_count, comparisons, pulses} = {32'd0, 32'd0, 32'd0};
    tick(5);
    rst = 1'b0;
    t_reset;
    t_ports;
    t_override;
    t_strobe_in(8'h18);
    t_strobe_in(8'h3E);
    t_strobe_out;
    t_timer;
    stop_test;
  end
endmodule
`default_nettype wire
